/* File: flash_erase_pkg.sv */
package flash_erase_pkg;

    // register offsets on the plain register port
    localparam logic [3:0] CTRL_ADDR = 4'h0;
    localparam logic [3:0] PROT_ADDR = 4'h1;
    localparam logic [3:0] STAT_ADDR = 4'h2;
    localparam logic [3:0] SEQERR_ADDR = 4'h3;

    // control register fields
    localparam int CTRL_ERASE_BIT = 0;
    localparam int CTRL_MASS_BIT = 1;
    localparam int CTRL_HV_BIT = 3;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] PROT_RESET = 8'hff;

    // status register fields
    localparam int STAT_ARMED_BIT = 0;
    localparam int STAT_HV_BIT = 1;
    localparam int STAT_RECOVER_BIT = 2;
    localparam int STAT_READY_BIT = 3;
    localparam int STAT_DONE_BIT = 4;
    localparam int STAT_PROT_SEEN_BIT = 5;

    // flash array geometry
    localparam int ARRAY_ADDR_W = 15;
    localparam int ARRAY_WORDS = 24576;
    localparam logic [7:0] ERASED_VALUE = 8'hff;

    // timing
    localparam int CLK_MHZ = 40;
    localparam int RECOVERY_TIME_US = 1;
    localparam int RECOVERY_CYCLES = RECOVERY_TIME_US * CLK_MHZ;
    localparam int SETUP_TIME_US = 10;
    localparam int SETUP_CYCLES = SETUP_TIME_US * CLK_MHZ;
    localparam int ERASE_TIME_US = 4000;
    localparam int ERASE_CYCLES = ERASE_TIME_US * CLK_MHZ;
    localparam int HOLD_TIME_US = 100;
    localparam int HOLD_CYCLES = HOLD_TIME_US * CLK_MHZ;
    localparam int CNT_W = 18;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SELECTED = 3'b001,
        ST_PROT_READ = 3'b011,
        ST_ARMED = 3'b010,
        ST_HV_ON = 3'b110,
        ST_HOLD = 3'b111,
        ST_RECOVER = 3'b101
    } seq_state_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    typedef struct packed {
        logic [ARRAY_ADDR_W-1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } array_req_t;

endpackage

/* File: flash_array_clear.sv */
// walks every array location once while clear_i is high, one per cycle
module flash_array_clear (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic start_i,
    input wire logic clear_i,
    output logic [flash_erase_pkg::ARRAY_ADDR_W-1:0] addr_o,
    output logic we_o,
    output logic done_o
);
    logic [flash_erase_pkg::ARRAY_ADDR_W-1:0] addr_q, addr_d;
    logic busy_q, busy_d;
    logic done_q, done_d;

    localparam logic [flash_erase_pkg::ARRAY_ADDR_W-1:0] LAST =
        flash_erase_pkg::ARRAY_ADDR_W'(flash_erase_pkg::ARRAY_WORDS - 1);

    always_comb begin
        addr_d = addr_q;
        busy_d = busy_q;
        done_d = done_q;
        if (start_i) begin
            addr_d = '0;
            busy_d = 1'b1;
            done_d = 1'b0;
        end else if (busy_q && clear_i) begin
            if (addr_q == LAST) begin
                busy_d = 1'b0;
                done_d = 1'b1;
            end else begin
                addr_d = addr_q + 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            addr_q <= '0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            addr_q <= addr_d;
            busy_q <= busy_d;
            done_q <= done_d;
        end
    end

    assign addr_o = addr_q;
    assign we_o = busy_q && clear_i;
    assign done_o = done_q;
endmodule

/* File: flash_mass_erase_sequencer.sv */
// Operation
// - whole-array erase clears every program flash location, no subset.
// - any write into flash range arms the erase; data is ignored.
// - array readable 1 us after high voltage drops; no reads before.
// - steps in order; unrelated bus activity between steps is tolerated.
//
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
module flash_mass_erase_sequencer (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    input wire logic [flash_erase_pkg::ARRAY_ADDR_W-1:0] arr_addr_i,
    input wire logic [7:0] arr_wdata_i,
    input wire logic arr_wr_i,
    input wire logic arr_rd_i,
    output logic [7:0] arr_rdata_o,
    output logic arr_ready_o,
    output logic erase_hv_o,
    output logic erase_done_o
);
    ////////////////////////////////////////////////////////////////////////
    flash_erase_pkg::reg_req_t reg_req;
    flash_erase_pkg::array_req_t arr_req;

    assign reg_req = '{addr: reg_addr_i, wdata: reg_wdata_i,
                       wr: reg_wr_i, rd: reg_rd_i};
    assign arr_req = '{addr: arr_addr_i, wdata: arr_wdata_i,
                       wr: arr_wr_i, rd: arr_rd_i};

    localparam logic [flash_erase_pkg::CNT_W-1:0] RCV_N =
        flash_erase_pkg::CNT_W'(flash_erase_pkg::RECOVERY_CYCLES);

    flash_erase_pkg::seq_state_t state_q, state_d;
    logic erase_q, erase_d;
    logic mass_q, mass_d;
    logic hv_q, hv_d;
    logic [7:0] prot_q;
    logic prot_seen_q, prot_seen_d;
    logic seq_err_q, seq_err_d;
    logic [flash_erase_pkg::CNT_W-1:0] cnt_q, cnt_d;
    logic done_q, done_d;
    logic [7:0] rdata_q, rdata_d;
    logic [7:0] ardata_q, ardata_d;
    logic hv_out_q, hv_out_d;
    logic ready_q, ready_d;
    logic [7:0] mem [flash_erase_pkg::ARRAY_WORDS];

    logic clr_start, clr_done;
    logic [flash_erase_pkg::ARRAY_ADDR_W-1:0] clr_addr;
    logic clr_we;
    logic ctrl_wr, prot_rd, arm_wr, hv_active, arr_in_range;

    ////////////////////////////////////////////////////////////////////////
    // register port decode
    assign ctrl_wr = reg_req.wr &&
                     reg_req.addr == flash_erase_pkg::CTRL_ADDR;
    assign prot_rd = reg_req.rd &&
                     reg_req.addr == flash_erase_pkg::PROT_ADDR;
    assign arr_in_range = 32'(arr_req.addr) < flash_erase_pkg::ARRAY_WORDS;
    assign arm_wr = arr_req.wr && arr_in_range;

    // erase voltage gated on every arming condition; kept through the hold
    assign hv_active = hv_q &&
                       (state_q == flash_erase_pkg::ST_HOLD ||
                        (erase_q && mass_q &&
                         (state_q == flash_erase_pkg::ST_ARMED ||
                          state_q == flash_erase_pkg::ST_HV_ON)));

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        erase_d = erase_q;
        mass_d = mass_q;
        hv_d = hv_q;
        if (ctrl_wr) begin
            erase_d = reg_req.wdata[flash_erase_pkg::CTRL_ERASE_BIT];
            mass_d = reg_req.wdata[flash_erase_pkg::CTRL_MASS_BIT];
            hv_d = reg_req.wdata[flash_erase_pkg::CTRL_HV_BIT];
        end
    end

    // sequence tracker; unrelated traffic leaves the state alone
    always_comb begin
        state_d = state_q;
        prot_seen_d = prot_seen_q;
        seq_err_d = seq_err_q;
        cnt_d = cnt_q;
        clr_start = 1'b0;
        // clear first so that an error set in the same cycle wins
        if (reg_req.wr && reg_req.addr == flash_erase_pkg::SEQERR_ADDR &&
            reg_req.wdata[0]) begin
            seq_err_d = 1'b0;
        end
        unique case (state_q)
            flash_erase_pkg::ST_IDLE: begin
                if (erase_d && mass_d && !hv_d) begin
                    state_d = flash_erase_pkg::ST_SELECTED;
                    prot_seen_d = 1'b0;
                end
            end
            flash_erase_pkg::ST_SELECTED: begin
                if (!(erase_d && mass_d)) begin
                    state_d = flash_erase_pkg::ST_IDLE;
                end else if (prot_rd) begin
                    state_d = flash_erase_pkg::ST_PROT_READ;
                    prot_seen_d = 1'b1;
                end else if (arm_wr || hv_d) begin
                    seq_err_d = 1'b1;
                end
            end
            flash_erase_pkg::ST_PROT_READ: begin
                if (!(erase_d && mass_d)) begin
                    state_d = flash_erase_pkg::ST_IDLE;
                end else if (arm_wr) begin
                    state_d = flash_erase_pkg::ST_ARMED;
                    clr_start = 1'b1;
                end else if (hv_d) begin
                    seq_err_d = 1'b1;
                end
            end
            flash_erase_pkg::ST_ARMED: begin
                if (!(erase_d && mass_d)) begin
                    state_d = flash_erase_pkg::ST_IDLE;
                end else if (hv_d) begin
                    state_d = flash_erase_pkg::ST_HV_ON;
                end
            end
            flash_erase_pkg::ST_HV_ON: begin
                if (!hv_d) begin
                    state_d = flash_erase_pkg::ST_RECOVER;
                    cnt_d = '0;
                end else if (!erase_d) begin
                    state_d = flash_erase_pkg::ST_HOLD;
                end
            end
            flash_erase_pkg::ST_HOLD: begin
                if (!hv_d) begin
                    state_d = flash_erase_pkg::ST_RECOVER;
                    cnt_d = '0;
                end
            end
            flash_erase_pkg::ST_RECOVER: begin
                if (cnt_q == RCV_N - 1'b1) begin
                    state_d = flash_erase_pkg::ST_IDLE;
                end else begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
            default: state_d = flash_erase_pkg::ST_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // read data, array access and status outputs
    always_comb begin
        rdata_d = 8'h00;
        unique case (reg_req.addr)
            flash_erase_pkg::CTRL_ADDR: begin
                rdata_d[flash_erase_pkg::CTRL_ERASE_BIT] = erase_q;
                rdata_d[flash_erase_pkg::CTRL_MASS_BIT] = mass_q;
                rdata_d[flash_erase_pkg::CTRL_HV_BIT] = hv_q;
            end
            flash_erase_pkg::PROT_ADDR: rdata_d = prot_q;
            flash_erase_pkg::STAT_ADDR: begin
                rdata_d[flash_erase_pkg::STAT_ARMED_BIT] =
                    state_q == flash_erase_pkg::ST_ARMED;
                rdata_d[flash_erase_pkg::STAT_HV_BIT] = hv_out_q;
                rdata_d[flash_erase_pkg::STAT_RECOVER_BIT] =
                    state_q == flash_erase_pkg::ST_RECOVER;
                rdata_d[flash_erase_pkg::STAT_READY_BIT] = ready_q;
                rdata_d[flash_erase_pkg::STAT_DONE_BIT] = done_q;
                rdata_d[flash_erase_pkg::STAT_PROT_SEEN_BIT] = prot_seen_q;
            end
            flash_erase_pkg::SEQERR_ADDR: rdata_d = {7'h00, seq_err_q};
            default: rdata_d = 8'h00;
        endcase
        if (!reg_req.rd) begin
            rdata_d = 8'h00;
        end
        ardata_d = 8'h00;
        if (arr_req.rd && ready_q && arr_in_range) begin
            ardata_d = mem[arr_req.addr];
        end
        hv_out_d = hv_active;
        ready_d = state_d == flash_erase_pkg::ST_IDLE ||
                  state_d == flash_erase_pkg::ST_SELECTED ||
                  state_d == flash_erase_pkg::ST_PROT_READ;
        done_d = done_q;
        if (clr_start) begin
            done_d = 1'b0;
        end else if (clr_done &&
                     state_q == flash_erase_pkg::ST_RECOVER) begin
            done_d = 1'b1;
        end
    end

    // whole array walked under erase voltage
    flash_array_clear u_clear (
        .core_clk_i(core_clk_i),
        .resetn_i(resetn_i),
        .start_i(clr_start),
        .clear_i(hv_active),
        .addr_o(clr_addr),
        .we_o(clr_we),
        .done_o(clr_done)
    );

    always_ff @(posedge core_clk_i) begin
        if (clr_we) begin
            mem[clr_addr] <= flash_erase_pkg::ERASED_VALUE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_q <= flash_erase_pkg::ST_IDLE;
            erase_q <= 1'b0;
            mass_q <= 1'b0;
            hv_q <= 1'b0;
            prot_q <= flash_erase_pkg::PROT_RESET;
            prot_seen_q <= 1'b0;
            seq_err_q <= 1'b0;
            cnt_q <= '0;
            done_q <= 1'b0;
            rdata_q <= 8'h00;
            ardata_q <= 8'h00;
            hv_out_q <= 1'b0;
            ready_q <= 1'b1;
        end else begin
            state_q <= state_d;
            erase_q <= erase_d;
            mass_q <= mass_d;
            hv_q <= hv_d;
            prot_q <= flash_erase_pkg::PROT_RESET;
            prot_seen_q <= prot_seen_d;
            seq_err_q <= seq_err_d;
            cnt_q <= cnt_d;
            done_q <= done_d;
            rdata_q <= rdata_d;
            ardata_q <= ardata_d;
            hv_out_q <= hv_out_d;
            ready_q <= ready_d;
        end
    end

    assign reg_rdata_o = rdata_q;
    assign arr_rdata_o = ardata_q;
    assign arr_ready_o = ready_q;
    assign erase_hv_o = hv_out_q;
    assign erase_done_o = done_q;
endmodule

/* File: flash_mass_erase_sequencer_props.sv */
module flash_mass_erase_sequencer_props (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic arr_rd_i,
    input wire logic [7:0] arr_rdata_o,
    input wire logic arr_ready_o,
    input wire logic erase_hv_o,
    input wire logic erase_done_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    logic [5:0] since_q;
    logic [5:0] since_d;
    // cycles since erase voltage was last seen, saturating
    always_comb begin
        since_d = since_q;
        if (erase_hv_o) since_d = 6'h00;
        else if (since_q != 6'h3f) since_d = since_q + 6'h01;
    end
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) since_q <= 6'h3f;
        else since_q <= since_d;
    end
    ////////////////////////////////////////////////////////////////////////
    reg_idle_a: assert property (!$past(reg_rd_i)
        |-> reg_rdata_o == 8'h00) else $error("read data outside read slot");
    prot_read_a: assert property ($past(reg_rd_i && reg_addr_i == 4'h1)
        |-> reg_rdata_o == 8'hff) else $error("protect read value");
    unmapped_read_a: assert property ($past(reg_rd_i
        && reg_addr_i > 4'h3) |-> reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    arr_idle_a: assert property ($past(!arr_rd_i || !arr_ready_o)
        |-> arr_rdata_o == 8'h00) else $error("array data while not ready");
    hv_cause_a: assert property ($rose(erase_hv_o) |-> $past(reg_wr_i
        && reg_addr_i == 4'h0 && reg_wdata_i[3], 2))
        else $error("erase voltage without enable write");
    hv_drop_a: assert property (reg_wr_i && reg_addr_i == 4'h0
        && !reg_wdata_i[3] |-> ##2 !erase_hv_o)
        else $error("erase voltage kept after enable cleared");
    hv_busy_a: assert property (erase_hv_o |-> !arr_ready_o)
        else $error("array ready under erase voltage");
    recover_time_a: assert property ($rose(arr_ready_o)
        |-> since_q >= 6'h26) else $error("array ready before recovery");
    done_recover_a: assert property ($rose(erase_done_o)
        |-> !arr_ready_o) else $error("done outside recovery");
endmodule

bind flash_mass_erase_sequencer flash_mass_erase_sequencer_props props_i (
    .core_clk_i(core_clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .arr_rd_i(arr_rd_i),
    .arr_rdata_o(arr_rdata_o), .arr_ready_o(arr_ready_o),
    .erase_hv_o(erase_hv_o), .erase_done_o(erase_done_o)
);

/* File: tb.sv */
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    flash_erase_pkg::reg_req_t rq = '0;
    flash_erase_pkg::array_req_t aq = '0;
    logic [7:0] reg_rdata;
    logic [7:0] arr_rdata;
    logic arr_ready;
    logic erase_hv;
    logic erase_done;
    int miscompares = 0;
    int n_tests = 0;
    int seed = 99;
    int i;

    always #12.5 core_clk_i = ~core_clk_i;

    flash_mass_erase_sequencer flash_mass_erase_sequencer_i (
        .core_clk_i(core_clk_i), .resetn_i(resetn_i),
        .reg_addr_i(rq.addr), .reg_wdata_i(rq.wdata), .reg_wr_i(rq.wr),
        .reg_rd_i(rq.rd), .reg_rdata_o(reg_rdata),
        .arr_addr_i(aq.addr), .arr_wdata_i(aq.wdata), .arr_wr_i(aq.wr),
        .arr_rd_i(aq.rd), .arr_rdata_o(arr_rdata), .arr_ready_o(arr_ready),
        .erase_hv_o(erase_hv), .erase_done_o(erase_done)
    );
    ////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        if (miscompares == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    function automatic logic [14:0] raddr(input int span, input int base);
        return 15'(base + ($unsigned($random(seed)) % span));
    endfunction

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        rq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk_i);
        rq.wr <= 1'b0;
    endtask

    // register read, data compared under a mask in the slot after the strobe
    task automatic rdc(input logic [3:0] a, input logic [7:0] m,
                       input logic [7:0] e, input string nm);
        @(posedge core_clk_i);
        rq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk_i);
        rq.rd <= 1'b0;
        #1 chk(nm, e, reg_rdata & m);
    endtask

    task automatic arr(input logic [14:0] a, input logic w,
                       input logic [7:0] e);
        @(posedge core_clk_i);
        aq <= '{addr: a, wdata: 8'($random(seed)), wr: w, rd: !w};
        @(posedge core_clk_i);
        aq <= '0;
        #1 if (!w) chk("array", e, arr_rdata);
    endtask

    // unrelated traffic between erase steps
    task automatic noise();
        rdc(4'h4 + 4'($unsigned($random(seed)) % 12), 8'hff, 8'h00,
            "unmapped");
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        #2000000;
        miscompares++;
        end_sim();
    end

    initial begin
        repeat (8) @(posedge core_clk_i);
        resetn_i <= 1'b1;
        chk("ready", 8'h01, {7'h00, arr_ready});
        rdc(4'h0, 8'hff, flash_erase_pkg::CTRL_RESET, "ctrl");
        rdc(4'h1, 8'hff, flash_erase_pkg::PROT_RESET, "protect");
        wr(4'h9, 8'hff);
        noise();
        // arming before the protect read, then voltage: both out of order
        wr(4'h0, 8'h03);
        arr(raddr(24576, 0), 1'b1, 8'h00);
        wr(4'h0, 8'h0b);
        repeat (4) @(posedge core_clk_i);
        chk("hv unarmed", 8'h00, {7'h00, erase_hv});
        // clear while the voltage request still stands: the set wins
        wr(4'h3, 8'h01);
        rdc(4'h3, 8'h01, 8'h01, "seq error");
        wr(4'h0, 8'h00);
        wr(4'h3, 8'h01);
        rdc(4'h3, 8'h01, 8'h00, "seq clear");
        wr(4'h0, 8'h03);
        rdc(4'h1, 8'hff, 8'hff, "protect");
        arr(raddr(8192, 24576), 1'b1, 8'h00);
        rdc(4'h2, 8'h01, 8'h00, "armed out of range");
        noise();
        arr(raddr(24576, 0), 1'b1, 8'h00);
        rdc(4'h2, 8'h01, 8'h01, "armed");
        arr(raddr(24576, 0), 1'b0, 8'h00);
        repeat (flash_erase_pkg::SETUP_CYCLES) @(posedge core_clk_i);
        wr(4'h0, 8'h0b);
        repeat (2) @(posedge core_clk_i);
        #1 chk("hv on", 8'h01, {7'h00, erase_hv});
        noise();
        arr(15'h0000, 1'b0, 8'h00);
        // erase wait cut to one clearing pass of the array to bound the run
        repeat (flash_erase_pkg::ARRAY_WORDS + 8) @(posedge core_clk_i);
        wr(4'h0, 8'h08);
        noise();
        repeat (flash_erase_pkg::HOLD_CYCLES) @(posedge core_clk_i);
        wr(4'h0, 8'h00);
        i = 0;
        while (arr_ready !== 1'b1 && i < 200) begin
            @(posedge core_clk_i);
            #1 i++;
        end
        chk("recovery", 8'h01,
            {7'h00, i == flash_erase_pkg::RECOVERY_CYCLES});
        chk("done", 8'h01, {7'h00, erase_done});
        arr(15'h0000, 1'b0, 8'hff);
        arr(15'(flash_erase_pkg::ARRAY_WORDS - 1), 1'b0, 8'hff);
        for (int k = 0; k < 16; k++) arr(raddr(24576, 0), 1'b0, 8'hff);
        end_sim();
    end
endmodule
